// ### logic/sampler_pkg.sv
`default_nettype none

// ****************************************************************
// Shared constants of the fetch sampling unit.
// ****************************************************************
package sampler_pkg;

  // Widths of the bus, the counter and the captured values.
  localparam int ADDR_W = 12;
  localparam int CNT_W = 20;
  localparam int LAT_W = 16;
  localparam int LIN_W = 64;
  localparam int PHYS_W = 52;

  // Byte addresses of the registers on the bus.
  localparam logic [ADDR_W-1:0] ADDR_CTL_LO = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CTL_HI = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_LIN_LO = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_LIN_HI = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_PHYS_LO = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_PHYS_HI = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 12'h01C;
  localparam logic [ADDR_W-1:0] ADDR_FEATURE = 12'h020;

  // Field positions in the low control word.
  localparam int LIMIT_LSB = 0;
  localparam int START_LSB = 16;

  // Field positions in the high control word.
  localparam int LAT_LSB = 0;
  localparam int EN_BIT = 16;
  localparam int VAL_BIT = 17;
  localparam int RANDEN_BIT = 25;

  // Interrupt status bit for a finished sample.
  localparam int IRQ_SAMPLE_BIT = 0;

  // Values after reset, and the first and the largest latency.
  localparam logic [15:0] RST_LIMIT = 16'h0000;
  localparam logic [15:0] RST_START = 16'h0000;
  localparam logic [7:0] RST_LFSR = 8'hA5;
  localparam logic [LAT_W-1:0] LAT_FIRST = 16'h0001;
  localparam logic [LAT_W-1:0] LAT_MAX = 16'hFFFF;

  // Feature word: bit 0 reports that fetch sampling exists.
  localparam logic [31:0] FEATURE_WORD = 32'h0000_0001;

  // Sampling sequence, one-hot.
  typedef enum logic [3:0] {
    S_COUNT = 4'b0001,
    S_TAG = 4'b0010,
    S_TRACK = 4'b0100,
    S_HOLD = 4'b1000
  } samp_state_e;

  // True for a word-aligned address that names a register.
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_FEATURE);
  endfunction

endpackage

`default_nettype wire

// ### logic/fetch_capture_if.sv
`default_nettype none

// ****************************************************************
// Link between the sampling core and the fetch tracker.
// ****************************************************************
interface fetch_capture_if;
  import sampler_pkg::*;

  // Core to tracker: the tag pulse and the live fetch signals.
  logic start_tag;
  logic done;
  logic abort;
  logic [LIN_W-1:0] lin;
  logic [PHYS_W-1:0] phys;
  logic ic_miss;
  logic tlb_miss;
  logic [1:0] pgsz;
  logic phys_ok;

  // Tracker to core: progress and the captured sample.
  logic busy;
  logic capture;
  logic [LAT_W-1:0] lat_q;
  logic comp_q;
  logic ic_miss_q;
  logic tlb_miss_q;
  logic [1:0] pgsz_q;
  logic physv_q;
  logic [LIN_W-1:0] lin_q;
  logic [PHYS_W-1:0] phys_q;

  // Side of the tracker.
  modport tracker (
    input start_tag, done, abort, lin, phys, ic_miss, tlb_miss, pgsz, phys_ok,
    output busy, capture, lat_q, comp_q, ic_miss_q, tlb_miss_q, pgsz_q, physv_q, lin_q, phys_q
  );

  // Side of the sampling core.
  modport core (
    output start_tag, done, abort, lin, phys, ic_miss, tlb_miss, pgsz, phys_ok,
    input busy, capture, lat_q, comp_q, ic_miss_q, tlb_miss_q, pgsz_q, physv_q, lin_q, phys_q
  );

endinterface

`default_nettype wire

// ### logic/fetch_tracker.sv
`default_nettype none

// ****************************************************************
// Follows one tagged fetch and captures its outcome.
// ****************************************************************
module fetch_tracker (
  input wire logic i_clock,
  input wire logic i_resetn,
  fetch_capture_if.tracker cap
);
  import sampler_pkg::*;

  logic busy_q, busy_d; // A tagged fetch is in flight.
  logic capture_q, capture_d; // One-cycle pulse: capture registers just loaded.
  logic [LAT_W-1:0] lat_q, lat_d; // Cycles spent by the tagged fetch.
  logic comp_q, comp_d; // The fetch completed rather than aborted.
  logic ic_q, ic_d; // Instruction cache miss.
  logic tlb_q, tlb_d; // Translation buffer miss.
  logic [1:0] pg_q, pg_d; // Page size of the translation.
  logic pv_q, pv_d; // Physical address and page size are valid.
  logic [LIN_W-1:0] lin_q, lin_d; // Linear address of the fetch.
  logic [PHYS_W-1:0] phys_q, phys_d; // Physical address of the fetch.

  // Next values: start counting on the tag, freeze everything at the end.
  always_comb begin
    busy_d = busy_q;
    capture_d = 1'b0;
    lat_d = lat_q;
    comp_d = comp_q;
    ic_d = ic_q;
    tlb_d = tlb_q;
    pg_d = pg_q;
    pv_d = pv_q;
    lin_d = lin_q;
    phys_d = phys_q;
    if (cap.start_tag) begin
      // The tag cycle itself is the first cycle of the fetch.
      busy_d = 1'b1;
      lat_d = LAT_FIRST;
    end else if (busy_q) begin
      if (cap.done || cap.abort) begin
        // End of the fetch: record how it went.
        busy_d = 1'b0;
        capture_d = 1'b1;
        comp_d = cap.done;
        ic_d = cap.ic_miss;
        tlb_d = cap.tlb_miss;
        pg_d = cap.pgsz;
        pv_d = cap.phys_ok;
        lin_d = cap.lin;
        phys_d = cap.phys;
      end else if (lat_q != LAT_MAX) begin
        // Count the cycle, saturating so a hung fetch reads all ones.
        lat_d = lat_q + LAT_FIRST;
      end
    end
  end

  // Registers of the tracker.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q <= 1'b0;
      capture_q <= 1'b0;
      lat_q <= '0;
      comp_q <= 1'b0;
      ic_q <= 1'b0;
      tlb_q <= 1'b0;
      pg_q <= 2'h0;
      pv_q <= 1'b0;
      lin_q <= '0;
      phys_q <= '0;
    end else begin
      busy_q <= busy_d;
      capture_q <= capture_d;
      lat_q <= lat_d;
      comp_q <= comp_d;
      ic_q <= ic_d;
      tlb_q <= tlb_d;
      pg_q <= pg_d;
      pv_q <= pv_d;
      lin_q <= lin_d;
      phys_q <= phys_d;
    end
  end

  // Results back to the core.
  assign cap.busy = busy_q;
  assign cap.capture = capture_q;
  assign cap.lat_q = lat_q;
  assign cap.comp_q = comp_q;
  assign cap.ic_miss_q = ic_q;
  assign cap.tlb_miss_q = tlb_q;
  assign cap.pgsz_q = pg_q;
  assign cap.physv_q = pv_q;
  assign cap.lin_q = lin_q;
  assign cap.phys_q = phys_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // Each cycle of an unfinished fetch adds one to the latency, up to LAT_MAX.
  AST_LAT_STEP: assert property (
    busy_q && !cap.done && !cap.abort && !cap.start_tag && lat_q != LAT_MAX |=> lat_q == $past(lat_q) + LAT_FIRST)
    else $error("Latency did not advance by one.");

  // The end of the fetch raises the capture pulse with the validity flag taken.
  AST_PHYSV_CAPTURE: assert property (
    busy_q && !cap.start_tag && (cap.done || cap.abort) |=> capture_q && pv_q == $past(cap.phys_ok) && !busy_q)
    else $error("Capture or physical-valid flag wrong at end of fetch.");

  // An aborted fetch is captured as not completed.
  AST_ABORT_STATUS: assert property (
    busy_q && !cap.start_tag && cap.abort && !cap.done |=> !comp_q)
    else $error("Aborted fetch shown as completed.");

  COV_ABORT: cover property (busy_q && cap.abort);

endmodule

`default_nettype wire

// ### logic/fetch_sampler.sv
`default_nettype none

// How it works
// - Count completed fetches while enabled, until counter bits 19:4 equal limit.
// - Counter bits 19:4 equal limit: tag next fetch.
// - Tagged fetch end writes status and both addresses.
// - Then set valid flag and raise interrupt.
// - New sample loads counter bits 19:4 from start.
// - Re-arm: low bits random if enabled, else zero.
// - Record outcome, latency, misses, page size, addresses.
// - Fetch sampling has its own control and state.
// - Feature word reports that fetch sampling exists.
// - Latency counts cycles from start to delivery or abort.
// - Counter holds still while valid is set, except on re-arm or when software writes the count field.
// - Count field reads counter bits 19:4; write sets them.
// - Physical-valid flag only when address and size valid.

// ****************************************************************
// Fetch sampling unit: APB registers, interval counter, tagging.
// ****************************************************************
module fetch_sampler (
  input wire logic i_clock,
  input wire logic i_resetn,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [sampler_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Fetch pipeline.
  input wire logic i_fetch_start,
  input wire logic i_fetch_done,
  input wire logic i_fetch_abort,
  input wire logic [sampler_pkg::LIN_W-1:0] i_fetch_lin_addr,
  input wire logic [sampler_pkg::PHYS_W-1:0] i_fetch_phys_addr,
  input wire logic i_fetch_ic_miss,
  input wire logic i_fetch_tlb_miss,
  input wire logic [1:0] i_fetch_page_size,
  input wire logic i_fetch_phys_ok,
  output logic o_fetch_tag,
  // Interrupt request to the interrupt controller.
  output logic o_irq
);
  import sampler_pkg::*;

  // ****************************************************************
  // State and bus decode.
  // ****************************************************************
  samp_state_e state_q, state_d; // Where the sampling sequence stands.
  logic [CNT_W-1:0] cnt_q, cnt_d; // Fetch interval counter.
  logic [15:0] limit_q, limit_d; // Programmed interval limit.
  logic [15:0] start_q, start_d; // Programmed start value for a new sample.
  logic en_q, en_d; // Sampling enable.
  logic randen_q, randen_d; // Randomize the low counter bits.
  logic [7:0] lfsr_q, lfsr_d; // Free-running pseudo-random source.
  logic stat_q, stat_d; // Sticky interrupt status.
  logic mask_q, mask_d; // Interrupt mask, one enables.
  logic [31:0] rdata_q, rdata_d; // Read data, loaded in the setup cycle.
  logic valid; // Sample-valid flag as software sees it.
  logic wr, wr_lo, wr_hi, wr_stat, wr_mask; // Write strobes at the access edge.
  logic rearm; // Software clears the valid flag of a held sample.
  logic match; // Counter has reached the limit.
  logic [3:0] low_bits; // Low counter bits for a reload.
  logic [31:0] ctl_hi; // Assembled high control word.
  fetch_capture_if cap (); // Link to the tracker.

  // The valid flag is exactly the hold state.
  assign valid = (state_q == S_HOLD);

  // Writes take effect on the single access edge; the slave never waits.
  assign wr = i_psel && i_penable && i_pwrite && addr_mapped(i_paddr);
  assign wr_lo = wr && (i_paddr == ADDR_CTL_LO);
  assign wr_hi = wr && (i_paddr == ADDR_CTL_HI);
  assign wr_stat = wr && (i_paddr == ADDR_INT_STATUS);
  assign wr_mask = wr && (i_paddr == ADDR_INT_MASK);

  // Re-arm only when a held sample has its valid bit written to zero.
  assign rearm = wr_hi && valid && !i_pwdata[VAL_BIT];
  assign match = (cnt_q[CNT_W-1:4] == limit_q);
  assign low_bits = randen_q ? lfsr_q[3:0] : 4'h0;

  // ****************************************************************
  // Interval counter and sampling sequence.
  // ****************************************************************

  // Next state of the counter and the sequence.
  always_comb begin
    cnt_d = cnt_q;
    state_d = state_q;
    if (rearm) begin
      // A new sample starts from the programmed value.
      cnt_d = {start_q, low_bits};
    end else if (wr_lo) begin
      // Software writes the live counter through the count field.
      cnt_d = {i_pwdata[START_LSB +: 16], low_bits};
    end else if (state_q == S_COUNT && en_q && !match && i_fetch_done) begin
      // Only counting state advances; hold and tracking freeze it.
      cnt_d = cnt_q + 20'h00001;
    end
    case (state_q)
      S_COUNT: begin
        if (en_q && match) begin
          state_d = S_TAG;
        end
      end
      S_TAG: begin
        if (!en_q) begin
          state_d = S_COUNT;
        end else if (i_fetch_start) begin
          state_d = S_TRACK;
        end
      end
      S_TRACK: begin
        if (cap.capture) begin
          state_d = S_HOLD;
        end
      end
      S_HOLD: begin
        if (rearm) begin
          state_d = S_COUNT;
        end
      end
      default: begin
        state_d = S_COUNT;
      end
    endcase
  end

  // Registers of the counter and sequence; reset disables sampling.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      state_q <= S_COUNT;
    end else begin
      cnt_q <= cnt_d;
      state_q <= state_d;
    end
  end

  // The tag goes to the first fetch that starts after the match.
  assign o_fetch_tag = (state_q == S_TAG) && en_q && i_fetch_start;

  // Drive the tracker with the tag and the live fetch signals.
  assign cap.start_tag = o_fetch_tag;
  assign cap.done = i_fetch_done;
  assign cap.abort = i_fetch_abort;
  assign cap.lin = i_fetch_lin_addr;
  assign cap.phys = i_fetch_phys_addr;
  assign cap.ic_miss = i_fetch_ic_miss;
  assign cap.tlb_miss = i_fetch_tlb_miss;
  assign cap.pgsz = i_fetch_page_size;
  assign cap.phys_ok = i_fetch_phys_ok;

  // Tracker that times the tagged fetch and holds its outcome.
  fetch_tracker u_tracker (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .cap(cap)
  );

  // ****************************************************************
  // Software registers and interrupt.
  // ****************************************************************

  // Next values of the programmed fields, status and random source.
  always_comb begin
    limit_d = limit_q;
    start_d = start_q;
    en_d = en_q;
    randen_d = randen_q;
    mask_d = mask_q;
    // The random source steps every cycle so reloads land apart.
    lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    if (wr_lo) begin
      limit_d = i_pwdata[LIMIT_LSB +: 16];
      start_d = i_pwdata[START_LSB +: 16];
    end
    if (wr_hi) begin
      en_d = i_pwdata[EN_BIT];
      randen_d = i_pwdata[RANDEN_BIT];
    end
    if (wr_mask) begin
      mask_d = i_pwdata[IRQ_SAMPLE_BIT];
    end
    // Write one clears; a capture in the same cycle wins.
    stat_d = (stat_q && !(wr_stat && i_pwdata[IRQ_SAMPLE_BIT])) || cap.capture;
  end

  // Registers of the programmed fields.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      limit_q <= RST_LIMIT;
      start_q <= RST_START;
      en_q <= 1'b0;
      randen_q <= 1'b0;
      lfsr_q <= RST_LFSR;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
    end else begin
      limit_q <= limit_d;
      start_q <= start_d;
      en_q <= en_d;
      randen_q <= randen_d;
      lfsr_q <= lfsr_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // Level interrupt while the unmasked status bit is set.
  assign o_irq = stat_q && mask_q;

  // High control word: captured status beside enable and valid.
  assign ctl_hi = {6'h00, randen_q, 1'b0, cap.tlb_miss_q, cap.pgsz_q, cap.physv_q, cap.ic_miss_q,
                   cap.comp_q, valid, en_q, cap.lat_q};

  // Read mux, sampled in the setup cycle and shown in the access cycle.
  always_comb begin
    rdata_d = rdata_q;
    if (i_psel && !i_penable) begin
      case (i_paddr)
        ADDR_CTL_LO: rdata_d = {cnt_q[CNT_W-1:4], limit_q};
        ADDR_CTL_HI: rdata_d = ctl_hi;
        ADDR_LIN_LO: rdata_d = cap.lin_q[31:0];
        ADDR_LIN_HI: rdata_d = cap.lin_q[63:32];
        ADDR_PHYS_LO: rdata_d = cap.phys_q[31:0];
        ADDR_PHYS_HI: rdata_d = {12'h000, cap.phys_q[51:32]};
        ADDR_INT_STATUS: rdata_d = {31'h00000000, stat_q};
        ADDR_INT_MASK: rdata_d = {31'h00000000, mask_q};
        ADDR_FEATURE: rdata_d = FEATURE_WORD;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error.
  assign o_prdata = rdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_mapped(i_paddr);

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  AST_COUNT_STEP: assert property (
    state_q == S_COUNT && en_q && !match && i_fetch_done && !wr_lo && !rearm |=> cnt_q == $past(cnt_q) + 20'h00001)
    else $error("Counter did not step on a completed fetch.");

  AST_TAG_ON_MATCH: assert property (
    state_q == S_COUNT && en_q && match |=> state_q == S_TAG)
    else $error("Limit reached but no tag armed.");

  AST_CAPTURE_VALID: assert property (
    state_q == S_TRACK && cap.capture |=> valid && stat_q)
    else $error("Capture did not set valid and status.");

  AST_HOLD_FREEZE: assert property (
    valid && !rearm && !wr_lo |=> $stable(cnt_q))
    else $error("Counter moved while sample valid.");

  AST_REARM_LOAD: assert property (
    rearm |=> cnt_q[CNT_W-1:4] == $past(start_q) && state_q == S_COUNT)
    else $error("Re-arm did not load start value.");

  AST_LOW_ZERO: assert property (
    rearm && !randen_q |=> cnt_q[3:0] == 4'h0)
    else $error("Low counter bits not cleared on re-arm.");

  AST_WRITE_COUNT: assert property (
    wr_lo && !rearm |=> cnt_q[CNT_W-1:4] == $past(i_pwdata[31:16]))
    else $error("Count field write did not reach counter.");

  AST_NO_RETAG: assert property (
    valid |-> !o_fetch_tag)
    else $error("Fetch tagged while sample held.");

  AST_IRQ_LEVEL: assert property (
    cap.capture && mask_q && !wr_mask |=> o_irq ##1 (o_irq || $past(wr_stat) || $past(wr_mask)))
    else $error("Interrupt not raised after capture.");

  AST_TRACK_BUSY: assert property (
    state_q == S_TRACK && !cap.capture |-> cap.busy)
    else $error("Tracking state without a fetch in flight.");

  COV_TAG: cover property (o_fetch_tag);
  COV_CAPTURE: cover property (state_q == S_TRACK ##1 valid);
  COV_REARM: cover property (rearm && randen_q);

endmodule

`default_nettype wire

// ### bench/fetch_pipe_model.sv
`default_nettype none

// ****************************************************************
// Fetch pipeline model: runs one fetch block at a time on command.
// ****************************************************************
module fetch_pipe_model (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_go,
  input wire logic i_kill,
  input wire logic [7:0] i_len,
  input wire logic [63:0] i_lin,
  input wire logic [51:0] i_phys,
  input wire logic [4:0] i_flags,
  output logic o_start,
  output logic o_done,
  output logic o_abort,
  output logic [63:0] o_lin,
  output logic [51:0] o_phys,
  output logic o_ic_miss,
  output logic o_tlb_miss,
  output logic [1:0] o_page_size,
  output logic o_phys_ok
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] cnt_q; // Cycles left until the fetch in flight ends.
  logic end_q; // High in the cycle that ends the fetch.
  logic kill_q; // The fetch in flight ends by abort.
  logic [4:0] flags_q; // Outcome flags of the fetch in flight.

  // Takes a command only when idle, then ends the fetch i_len cycles after its start.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_start <= 1'b0;
      end_q <= 1'b0;
      cnt_q <= 8'h00;
      kill_q <= 1'b0;
      flags_q <= 5'h00;
    end else begin
      o_start <= 1'b0;
      end_q <= 1'b0;
      if (i_go && cnt_q == 8'h00 && !o_start) begin
        o_start <= 1'b1;
        cnt_q <= i_len;
        kill_q <= i_kill;
        flags_q <= i_flags;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
        end_q <= (cnt_q == 8'h01);
      end
    end
  end

  // Outcome lines hold meaning only in the ending cycle, so they show the inverse elsewhere.
  assign o_done = end_q && !kill_q;
  assign o_abort = end_q && kill_q;
  assign o_lin = end_q ? i_lin : ~i_lin;
  assign o_phys = end_q ? i_phys : ~i_phys;
  assign {o_ic_miss, o_tlb_miss, o_page_size, o_phys_ok} = end_q ? flags_q : ~flags_q;
endmodule

`default_nettype wire

// ### bench/fetch_sampler_bench.sv
`default_nettype none

// ****************************************************************
// Self-checking bench of the fetch sampling unit.
// ****************************************************************
module fetch_sampler_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sampler_pkg::*;

  logic clock = 1'b0; // Core clock, 40 ns period.
  logic resetn = 1'b0; // Reset, active low.
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB master controls.
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, tag, irq;
  logic go = 1'b0, kill = 1'b0; // Fetch command to the model.
  logic [7:0] len = 8'h02;
  logic [4:0] flags = 5'h00; // Icache miss, TLB miss, page size, physical ok.
  logic [LIN_W-1:0] lin = 64'h0123_4567_89AB_CDEF;
  logic [PHYS_W-1:0] phys = 52'hA_BCDE_F012_3456;
  logic f_start, f_done, f_abort, f_ic, f_tlb, f_ok;
  logic [1:0] f_pg;
  logic [LIN_W-1:0] f_lin;
  logic [PHYS_W-1:0] f_phys;
  int miscompares = 0, n_compared = 0;

  fetch_sampler u_fetch_sampler (.i_clock(clock), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_fetch_start(f_start), .i_fetch_done(f_done), .i_fetch_abort(f_abort),
    .i_fetch_lin_addr(f_lin), .i_fetch_phys_addr(f_phys), .i_fetch_ic_miss(f_ic), .i_fetch_tlb_miss(f_tlb),
    .i_fetch_page_size(f_pg), .i_fetch_phys_ok(f_ok), .o_fetch_tag(tag), .o_irq(irq));

  fetch_pipe_model u_fetch_pipe_model (.i_clock(clock), .i_resetn(resetn), .i_go(go), .i_kill(kill),
    .i_len(len), .i_lin(lin), .i_phys(phys), .i_flags(flags), .o_start(f_start), .o_done(f_done),
    .o_abort(f_abort), .o_lin(f_lin), .o_phys(f_phys), .o_ic_miss(f_ic), .o_tlb_miss(f_tlb),
    .o_page_size(f_pg), .o_phys_ok(f_ok));

  // Clock generator.
  initial begin
    forever #20 clock = ~clock;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; data and error are taken at the edge where pready is seen high.
  // The wait for pready has no limit of its own: only the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares it.
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp);
  endtask

  // Writes a register.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask

  // Checks the interrupt line once the last edge has settled.
  task automatic irq_is(input logic exp);
    @(negedge clock);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // Runs one fetch and tells whether its start cycle carried the tag.
  task automatic fetch(input logic [7:0] n, input logic k, input logic [4:0] fl, output logic t);
    int w;
    t = 1'b0;
    w = 0;
    @(posedge clock);
    go <= 1'b1;
    len <= n;
    kill <= k;
    flags <= fl;
    @(posedge clock);
    go <= 1'b0;
    while (!(f_done || f_abort) && w < 300) begin
      @(negedge clock);
      w++;
      if (f_start) begin
        t = tag;
      end
    end
    chk({31'h0, w < 300}, 32'h1);
    repeat (2) @(posedge clock);
  endtask

  // Runs short fetches that must all pass untagged.
  task automatic run_plain(input int n);
    logic t;
    int hits;
    hits = 0;
    for (int i = 0; i < n; i++) begin
      fetch(8'h02, 1'b0, 5'h00, t);
      hits += (t !== 1'b0);
    end
    chk(hits, 32'h0);
  endtask

  // Reset state, feature word and a refused address.
  task automatic test_reset();
    logic [31:0] d;
    logic e;
    rd(ADDR_CTL_HI, 32'h0000_0000);
    rd(ADDR_CTL_LO, 32'h0000_0000);
    rd(ADDR_FEATURE, 32'h0000_0001);
    apb(1'b0, 12'h040, 32'h0, d, e);
    chk(d, 32'h0);
    chk({31'h0, e}, 32'h1);
    irq_is(1'b0);
  endtask

  // Sixteen counted fetches reach the limit, the next one is captured in full.
  task automatic test_sample();
    logic t;
    wr(ADDR_INT_MASK, 32'h1);
    wr(ADDR_CTL_LO, 32'h0000_0001);
    wr(ADDR_CTL_HI, 32'h0001_0000);
    run_plain(16);
    fetch(8'h05, 1'b0, 5'b10101, t);
    chk({31'h0, t}, 32'h1);
    rd(ADDR_CTL_HI, 32'h005F_0005);
    rd(ADDR_LIN_LO, 32'h89AB_CDEF);
    rd(ADDR_LIN_HI, 32'h0123_4567);
    rd(ADDR_PHYS_LO, 32'hF012_3456);
    rd(ADDR_PHYS_HI, 32'h000A_BCDE);
    irq_is(1'b1);
    run_plain(2);
    rd(ADDR_CTL_LO, 32'h0001_0001);
  endtask

  // Re-arm reloads the counter, an aborted fetch is captured, masking gates the interrupt.
  task automatic test_rearm();
    logic [31:0] d;
    logic e, t;
    wr(ADDR_INT_MASK, 32'h0);
    wr(ADDR_INT_STATUS, 32'h1);
    rd(ADDR_INT_STATUS, 32'h0);
    wr(ADDR_CTL_HI, 32'h0001_0000);
    rd(ADDR_CTL_LO, 32'h0000_0001);
    run_plain(16);
    fetch(8'h03, 1'b1, 5'b01010, t);
    chk({31'h0, t}, 32'h1);
    apb(1'b0, ADDR_CTL_HI, 32'h0, d, e);
    chk(d & 32'hFF9F_FFFF, 32'h0083_0003);
    rd(ADDR_INT_STATUS, 32'h1);
    irq_is(1'b0);
    wr(ADDR_INT_MASK, 32'h1);
    irq_is(1'b1);
    wr(ADDR_INT_STATUS, 32'h1);
    irq_is(1'b0);
    wr(ADDR_CTL_LO, 32'h0005_0009);
    rd(ADDR_CTL_LO, 32'h0005_0009);
    wr(ADDR_CTL_HI, 32'h0203_0000);
    apb(1'b0, ADDR_CTL_HI, 32'h0, d, e);
    chk(d & 32'hFF9F_FFFF, 32'h0283_0003);
    wr(ADDR_CTL_HI, 32'h0201_0000);
    apb(1'b0, ADDR_CTL_HI, 32'h0, d, e);
    chk(d & 32'hFF9F_FFFF, 32'h0281_0003);
    rd(ADDR_CTL_LO, 32'h0005_0009);
  endtask

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    test_reset();
    test_sample();
    test_rearm();
    finish_test();
  end

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    finish_test();
  end
endmodule

`default_nettype wire
